// ===== src/miu_interrupt_unit.sv
/*
 * Interrupt unit: flags, enables, global enable, request and vector entry.
 * Assumes the core gives a one-cycle instruction-cycle enable, register writes
 * on the same clock, and the pc to push; pins and comparator arrive asynchronously.
 */
`timescale 1ns/100ps
module miu_interrupt_unit
    import miu_pkg::*;
#(
    parameter int PC_W = 13
) (
    input  wire logic            ref_clk,
    input  wire logic            rst,
    input  wire logic            icyc_en,
    input  wire logic            ext_irq_pin,
    input  wire logic [3:0]      port_b_upper_pins,
    input  wire logic            cmp_out,
    input  wire logic            base_timer_ovf,
    input  wire logic            ctl_wr,
    input  wire logic [7:0]      ctl_wdata,
    input  wire logic            pfl_wr,
    input  wire logic [7:0]      pfl_wdata,
    input  wire logic            pen_wr,
    input  wire logic [7:0]      pen_wdata,
    input  wire logic            return_from_irq,
    input  wire logic [PC_W-1:0] pc_now,
    output logic [7:0]           irq_control_reg,
    output logic [7:0]           periph_flag_reg,
    output logic [7:0]           periph_enable_reg,
    output logic                 irq_req,
    output logic                 force_nop,
    output logic                 vec_load,
    output logic [PC_W-1:0]      vec_addr,
    output logic                 stack_push,
    output logic [PC_W-1:0]      push_addr
);
    // ========================================================================
    // Three-stage synchronisers; stage one feeds only stage two.
    logic [5:0] s1_q, s2_q, s3_q;
    logic       ext_prev_q;
    logic [3:0] pb_prev_q;
    logic       cmp_prev_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_q <= 6'h00;
            s2_q <= 6'h00;
            s3_q <= 6'h00;
        end else begin
            s1_q <= {cmp_out, port_b_upper_pins, ext_irq_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A level moves only where stages two and three agree, bit by bit. The price is
    // that a pin pulse sampled on fewer than two clock edges is lost rather than half-seen.
    function automatic logic [5:0] agree_lvl(input logic [5:0] s2,
                                             input logic [5:0] s3,
                                             input logic [5:0] prev);
        logic [5:0] same;
        same      = ~(s2 ^ s3);
        agree_lvl = (same & s3) | (~same & prev);
    endfunction

    logic       ext_lvl, cmp_lvl;
    logic [3:0] pb_lvl;
    logic [5:0] lvl_all;
    assign lvl_all = agree_lvl(s2_q, s3_q, {cmp_prev_q, pb_prev_q, ext_prev_q});
    assign ext_lvl = lvl_all[0];
    assign pb_lvl  = lvl_all[4:1];
    assign cmp_lvl = lvl_all[5];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ext_prev_q <= 1'b0;
            pb_prev_q  <= 4'h0;
            cmp_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_lvl;
            pb_prev_q  <= pb_lvl;
            cmp_prev_q <= cmp_lvl;
        end
    end

    // ========================================================================
    // Events: rising edge on the pin, any change on the upper pins or comparator.
    logic ext_evt, pb_evt, cmp_evt;
    assign ext_evt = ext_lvl & ~ext_prev_q;
    assign pb_evt  = |(pb_lvl ^ pb_prev_q);
    assign cmp_evt = cmp_lvl ^ cmp_prev_q;

    // ========================================================================
    // Control and peripheral registers.
    logic [7:0] ctl_q, pfl_q, pen_q;
    logic       accept;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctl_q <= CTL_RST;
        end else begin
            if (ctl_wr) begin
                ctl_q <= ctl_wdata;
            end
            // Entry beats both a write and a return that land in the same cycle.
            if (accept) begin
                ctl_q[CTL_GEN_BIT] <= 1'b0;
            end else if (return_from_irq) begin
                ctl_q[CTL_GEN_BIT] <= 1'b1;
            end
            // Hardware sets win over a software clear in the same cycle.
            if (base_timer_ovf) begin
                ctl_q[CTL_TIF_BIT] <= 1'b1;
            end
            if (ext_evt) begin
                ctl_q[CTL_EIF_BIT] <= 1'b1;
            end
            if (pb_evt) begin
                ctl_q[CTL_CIF_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pfl_q <= PER_RST;
            pen_q <= PER_RST;
        end else begin
            if (pfl_wr) begin
                pfl_q <= pfl_wdata;
            end
            if (cmp_evt) begin
                pfl_q[PER_CMP_BIT] <= 1'b1;
            end
            if (pen_wr) begin
                pen_q <= pen_wdata;
            end
        end
    end

    // ========================================================================
    // Request: flags held until software clears them, so masked ones stay pending.
    logic pend;
    assign pend = (ctl_q[CTL_TIF_BIT] & ctl_q[CTL_TIE_BIT])
                | (ctl_q[CTL_EIF_BIT] & ctl_q[CTL_EIE_BIT])
                | (ctl_q[CTL_CIF_BIT] & ctl_q[CTL_CIE_BIT])
                | (ctl_q[CTL_PEIE_BIT] & pfl_q[PER_CMP_BIT] & pen_q[PER_CMP_BIT]);

    // A write that drops the global enable blocks the following cycle too.
    logic gen_drop_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gen_drop_q <= 1'b0;
        end else if (icyc_en) begin
            gen_drop_q <= ctl_wr & ~ctl_wdata[CTL_GEN_BIT] & ctl_q[CTL_GEN_BIT];
        end
    end

    logic take;
    assign take = ctl_q[CTL_GEN_BIT] & pend & ~gen_drop_q;

    // ========================================================================
    // Entry sequencer: the request is recognised, two cycles wait, then vectoring.
    // Together with the synchroniser this gives seven to eight cycles from the pin when every clock is an instruction cycle.
    miu_state_t st_q;
    logic [1:0] wait_q;
    // A request withdrawn while waiting is not entered; its flag stays pending.
    assign accept = icyc_en & take & (st_q == MIU_ENTER);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q   <= MIU_IDLE;
            wait_q <= 2'h0;
        end else if (icyc_en) begin
            case (st_q)
                MIU_IDLE: begin
                    if (take) begin
                        st_q   <= MIU_WAIT;
                        wait_q <= VEC_DELAY - 2'h1;
                    end
                end
                MIU_WAIT: begin
                    if (!take) begin
                        st_q <= MIU_IDLE;
                    end else if (wait_q == 2'h0) begin
                        st_q <= MIU_ENTER;
                    end else begin
                        wait_q <= wait_q - 2'h1;
                    end
                end
                MIU_ENTER: begin
                    st_q <= MIU_IDLE;
                end
                default: begin
                    st_q <= MIU_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_control_reg   <= CTL_RST;
            periph_flag_reg   <= PER_RST;
            periph_enable_reg <= PER_RST;
            irq_req           <= 1'b0;
            force_nop         <= 1'b0;
            vec_load          <= 1'b0;
            vec_addr          <= '0;
            stack_push        <= 1'b0;
            push_addr         <= '0;
        end else begin
            irq_control_reg   <= ctl_q;
            periph_flag_reg   <= pfl_q;
            periph_enable_reg <= pen_q;
            irq_req           <= take;
            force_nop         <= icyc_en & ctl_wr & ~ctl_wdata[CTL_GEN_BIT]
                                 & ctl_q[CTL_GEN_BIT];
            vec_load          <= accept;
            stack_push        <= accept;
            if (accept) begin
                vec_addr  <= IRQ_VECTOR[PC_W-1:0];
                push_addr <= pc_now;
            end
        end
    end
endmodule

// ===== src/miu_pkg.sv
/*
 * Constants and types of the microcontroller interrupt unit.
 * Assumes one core clock carrying a one-cycle instruction-cycle enable from the core.
 */
// Functional notes
// - Four sources: external pin, base timer overflow, port B upper pin change, comparator.
// - Control register holds the pin, timer and change flags, individual enables and one global enable.
// - Global enable bit 7 passes enabled sources when set, blocks all when clear.
// - Every reset forces the global enable to zero.
// - Return from interrupt restores return address and sets the global enable again; the unit only sets the global enable and restores no address.
// - Pin, change, timer flags in control register; comparator flag/enable in peripheral regs.
// - On accept: clear global enable, push return address, load vector 0004h.
// - Pin or change events reach the vector three or four instruction cycles later; the sequencer here waits two cycles, not one.
// - Flags set on events regardless of individual or global enable.
// - Clearing global enable ignores next-cycle interrupts; core runs a no-op then.
// - Ignored requests stay pending until the global enable is set again.
package miu_pkg;
    // ========================================================================
    // Control register bit positions.
    localparam int CTL_GEN_BIT  = 7;
    localparam int CTL_PEIE_BIT = 6;
    localparam int CTL_TIE_BIT  = 5;
    localparam int CTL_EIE_BIT  = 4;
    localparam int CTL_CIE_BIT  = 3;
    localparam int CTL_TIF_BIT  = 2;
    localparam int CTL_EIF_BIT  = 1;
    localparam int CTL_CIF_BIT  = 0;
    // Peripheral flag and enable registers: comparator bit.
    localparam int PER_CMP_BIT  = 6;
    // ========================================================================
    // Reset values and vector.
    localparam logic [7:0]  CTL_RST    = 8'h00;
    localparam logic [7:0]  PER_RST    = 8'h00;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    // Instruction cycles the sequencer waits in MIU_WAIT before it enters MIU_ENTER.
    localparam logic [1:0]  VEC_DELAY  = 2'h2;

    typedef enum logic [1:0] {
        MIU_IDLE  = 2'b00,
        MIU_WAIT  = 2'b01,
        MIU_ENTER = 2'b10
    } miu_state_t;
endpackage

// ===== verification/miu_core_model.sv
/* Core sequencer model: instruction-cycle enable and program counter.
   Assumes the unit's vector pulse and address arrive on the same clock. */
`timescale 1ns/100ps
module miu_core_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        vec_load,
    input  wire logic [12:0] vec_addr,
    output logic             icyc_en,
    output logic [12:0]      pc_now
);
    // Slow mode spaces instruction cycles two clocks apart, as a stalled core would.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            icyc_en <= 1'b0;
            pc_now  <= 13'h0000;
        end else begin
            icyc_en <= slow ? ~icyc_en : 1'b1;
            if (vec_load) begin
                pc_now <= vec_addr;
            end else if (icyc_en) begin
                pc_now <= pc_now + 13'h0001;
            end
        end
    end
endmodule

// ===== verification/miu_properties.sv
/* Concurrent checks on the interrupt unit's ports.
   Assumes it is bound to the unit's top module on one clock. */
`timescale 1ns/100ps
module miu_properties
    import miu_pkg::*;
#(
    parameter int PC_W = 13
) (
    input wire logic            ref_clk,
    input wire logic            rst,
    input wire logic            icyc_en,
    input wire logic            base_timer_ovf,
    input wire logic            ctl_wr,
    input wire logic [7:0]      ctl_wdata,
    input wire logic            return_from_irq,
    input wire logic [7:0]      irq_control_reg,
    input wire logic [7:0]      periph_flag_reg,
    input wire logic [7:0]      periph_enable_reg,
    input wire logic            irq_req,
    input wire logic            force_nop,
    input wire logic            vec_load,
    input wire logic [PC_W-1:0] vec_addr,
    input wire logic            stack_push
);
    logic [7:0] c;
    logic       any_en;
    assign c = irq_control_reg;
    assign any_en = (c[CTL_TIE_BIT] & c[CTL_TIF_BIT]) | (c[CTL_EIE_BIT] & c[CTL_EIF_BIT])
                  | (c[CTL_CIE_BIT] & c[CTL_CIF_BIT])
                  | (c[CTL_PEIE_BIT] & periph_flag_reg[PER_CMP_BIT]
                     & periph_enable_reg[PER_CMP_BIT]);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_gen_up; 1'b1 ##1 irq_control_reg[CTL_GEN_BIT]; endsequence
    property p_rst; disable iff (1'b0) $fell(rst) |-> !c[CTL_GEN_BIT] && !irq_req; endproperty
    property p_req; irq_req |-> c[CTL_GEN_BIT] && any_en; endproperty
    property p_vec; vec_load |-> vec_addr == PC_W'(IRQ_VECTOR); endproperty
    property p_pair; vec_load == stack_push; endproperty
    property p_gen_off; vec_load |=> !c[CTL_GEN_BIT]; endproperty
    property p_nop;
        force_nop |-> $past(ctl_wr && !ctl_wdata[CTL_GEN_BIT] && icyc_en) && !vec_load;
    endproperty
    property p_flag; base_timer_ovf && !ctl_wr |-> ##[1:2] c[CTL_TIF_BIT]; endproperty
    property p_ret; return_from_irq && !ctl_wr |=> vec_load or s_gen_up; endproperty
    a_rst: assert property (p_rst) else $error("global enable set after reset");
    a_req: assert property (p_req) else $error("request without enabled source");
    a_vec: assert property (p_vec) else $error("wrong vector address");
    a_pair: assert property (p_pair) else $error("push and vector load apart");
    a_gen_off: assert property (p_gen_off) else $error("enable kept on accept");
    a_nop: assert property (p_nop) else $error("no-op without cause");
    a_flag: assert property (p_flag) else $error("timer flag not set");
    a_ret: assert property (p_ret) else $error("return did not re-enable");
endmodule
bind miu_interrupt_unit miu_properties #(.PC_W(PC_W)) u_props (.ref_clk, .rst, .icyc_en,
    .base_timer_ovf, .ctl_wr, .ctl_wdata, .return_from_irq, .irq_control_reg,
    .periph_flag_reg, .periph_enable_reg, .irq_req, .force_nop, .vec_load, .vec_addr,
    .stack_push);

// ===== verification/tb_top.sv
/* Directed testbench of the interrupt unit with a core sequencer model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/100ps
module tb_top;
    import miu_pkg::*;
    logic ref_clk = 0, rst = 1, slow = 0, ext_irq_pin = 0, cmp_out = 0, base_timer_ovf = 0;
    logic ctl_wr = 0, pfl_wr = 0, pen_wr = 0, return_from_irq = 0, icyc_en;
    logic irq_req, force_nop, vec_load, stack_push;
    logic [3:0] port_b_upper_pins = 4'h0;
    logic [7:0] ctl_wdata = 8'h00, pfl_wdata = 8'h00, pen_wdata = 8'h00;
    logic [7:0] irq_control_reg, periph_flag_reg, periph_enable_reg;
    logic [12:0] pc_now, vec_addr, push_addr;
    logic [15:0] flags_exp [4] = '{16'h0004, 16'h0006, 16'h0007, 16'h4007};
    int err_count = 0, tests_run = 0, n;
    miu_interrupt_unit DUT (.ref_clk, .rst, .icyc_en, .ext_irq_pin, .port_b_upper_pins,
        .cmp_out, .base_timer_ovf, .ctl_wr, .ctl_wdata, .pfl_wr, .pfl_wdata, .pen_wr,
        .pen_wdata, .return_from_irq, .pc_now, .irq_control_reg, .periph_flag_reg,
        .periph_enable_reg, .irq_req, .force_nop, .vec_load, .vec_addr, .stack_push,
        .push_addr);
    miu_core_model u_core (.ref_clk, .rst, .slow, .vec_load, .vec_addr, .icyc_en, .pc_now);
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input int r, input logic [7:0] d);
        @(posedge ref_clk); #1;
        {ctl_wr, pfl_wr, pen_wr} = 3'b100 >> r;
        {ctl_wdata, pfl_wdata, pen_wdata} = {d, d, d};
        @(posedge ref_clk); #1;
        {ctl_wr, pfl_wr, pen_wr} = 3'b000;
    endtask
    // Sources 0 to 3 are timer, pin, port change and comparator; 4 is the return.
    // The pin is held three clocks; the input filter drops pulses sampled on fewer than two clock edges.
    task automatic pulse(input int k);
        @(posedge ref_clk); #1;
        case (k)
            0: base_timer_ovf = 1;
            1: ext_irq_pin = 1;
            2: port_b_upper_pins = ~port_b_upper_pins;
            3: cmp_out = ~cmp_out;
            default: return_from_irq = 1;
        endcase
        repeat ((k == 1) ? 3 : 1) @(posedge ref_clk);
        #1;
        {base_timer_ovf, ext_irq_pin, return_from_irq} = 3'b000;
    endtask
    // Outputs are looked at just after an edge, once they have settled.
    task automatic settle(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_vec();
        n = 0;
        do begin
            @(posedge ref_clk); #1;
            n++;
        end while (vec_load !== 1'b1 && n < 60);
    endtask
    task automatic end_of_test();
        if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #40000;
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 rst = 0;
        chk({irq_req, irq_control_reg}, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            pulse(k);
            settle(5);
            chk({periph_flag_reg, irq_control_reg}, flags_exp[k]);
        end
        chk(irq_req, 0);
        wr(0, 8'h00);
        wr(1, 8'h00);
        pulse(0);
        wr(0, 8'h24);
        settle(3);
        chk(irq_req, 0);
        wr(0, 8'ha4);
        wait_vec();
        chk(vec_addr, IRQ_VECTOR);
        chk({stack_push, 2'b00, push_addr}, {1'b1, 2'b00, pc_now - 13'h0001});
        settle(1);
        chk(irq_control_reg[CTL_GEN_BIT], 0);
        wr(0, 8'h30);
        pulse(4);
        settle(2);
        chk({irq_req, irq_control_reg}, 16'h00b0);
        for (int s = 0; s < 2; s++) begin
            slow = s[0];
            pulse(1);
            wait_vec();
            chk(n >= 3 * (s + 1) && n <= 9 * (s + 1), 1);
            wr(0, 8'h30);
            pulse(4);
        end
        slow = 0;
        wr(0, 8'h30);
        chk(force_nop, 1);
        pulse(0);
        settle(4);
        chk({vec_load, irq_req}, 0);
        pulse(4);
        wait_vec();
        chk(n < 20, 1);
        wr(0, 8'h40);
        wr(2, 8'h40);
        pulse(3);
        pulse(4);
        wait_vec();
        chk({periph_enable_reg, periph_flag_reg}, 16'h4040);
        chk(n < 20, 1);
        end_of_test();
    end
endmodule
